// ==== design/pmc_top.sv ====
// macrocell section: output cells, input cells, masks and external selects
`timescale 1ns/100ps
`include "pmc_defs.svh"

// Notes on behaviour
// - sixteen output cells, eight on port A pins, eight on port B pins.
// - XOR sets polarity; mux picks registered or combinational; result feeds back.
// - each cell storage acts as D, toggle, JK or set-reset flip-flop.
// - cell clock is a product term or cell clock pin rising edge.
// - preset and clear are active-high product terms; clear may use two.
// - 16-bit access: port A on bits 7-0, B on 15-8; swap reverses.
// - 8-bit bus uses only the low data byte for loads and reads.
// - port A cells own three terms; port B cells own four.
// - borrow only from the neighbour; a lent term is lost to its owner.
// - host load overrides product-term preset, clear and clock.
// - cells capture host data at the trailing edge of the write strobe.
// - host can read back current output cell flip-flop state.
// - per-group write mask, reset zero; a set bit blocks host writes.
// - pin driver enable is product term ORed with direction bit.
// - output pin with no enable equation is driven from the first clock after reset.
// - internal-node cells still feed back while the pin stays free.
// - 24 input cells on ports A, B, C: latch, register or pass.
// - input strobe is product term or address strobe, one per nibble.
// - host reads input cell outputs through a registered read buffer.
// - address-strobe-clocked input cells can hold upper address bits.
// - eight external selects, one product term each, selectable polarity.
// - external select driver enable from its term or direction bit.
// - input and output cells both sit on the internal data bus.
module pmc_top (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  config_space_select,
  input  wire logic [7:0]            host_addr,
  input  wire logic [15:0]           host_wdata,
  input  wire logic                  host_write_strobe_n,
  input  wire logic                  host_read_strobe_n,
  input  wire logic                  host_bus_16,
  input  wire logic                  host_byte_swap,
  input  wire logic                  address_latch_strobe,
  input  wire logic                  cell_clock_pin,
  input  wire logic [63:0]           oc_pt_term,
  input  wire logic [15:0]           oc_pt_second,
  input  wire logic [15:0]           oc_pt_clk,
  input  wire logic [15:0]           oc_pt_preset,
  input  wire logic [15:0]           oc_pt_clear0,
  input  wire logic [15:0]           oc_pt_clear1,
  input  wire logic [15:0]           oc_pt_oe,
  input  wire logic [15:0]           port_dir,
  input  pmc_pkg::pmc_ff_e [15:0]    oc_ff_type,
  input  wire logic [15:0]           oc_xor_inv,
  input  wire logic [15:0]           oc_use_reg,
  input  wire logic [15:0]           oc_clk_pin_sel,
  input  wire logic [15:0]           oc_internal_node,
  input  wire logic [15:0]           oc_oe_eq_en,
  input  wire logic [15:0]           oc_borrow_en,
  input  wire logic [7:0]            port_a_pins_in,
  input  wire logic [7:0]            port_b_pins_in,
  input  wire logic [7:0]            port_c_pins_in,
  input  pmc_pkg::pmc_imc_e [23:0]   ic_mode,
  input  wire logic [5:0]            ic_strobe_sel,
  input  wire logic [5:0]            ic_pt_strobe,
  input  wire logic [7:0]            ecs_pt,
  input  wire logic [7:0]            ecs_active_low,
  input  wire logic [7:0]            ecs_pt_oe,
  input  wire logic [7:0]            ecs_dir,
  input  wire logic [7:0]            ecs_oe_dir_sel,
  output logic [15:0]                host_rdata_q,
  output logic                       host_rdata_oe_n_q,
  output logic [7:0]                 port_a_out_q,
  output logic [7:0]                 port_a_oe_n_q,
  output logic [7:0]                 port_b_out_q,
  output logic [7:0]                 port_b_oe_n_q,
  output logic [15:0]                cell_feedback_q,
  output logic [15:0]                port_a_output_cells_q,
  output logic [23:0]                input_cell_q,
  output logic [7:0]                 external_select_q,
  output logic [7:0]                 external_select_oe_n_q
);
  import pmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0]  mask_a_q;
  logic [7:0]  mask_b_q;
  logic [7:0]  mask_a_d;
  logic [7:0]  mask_b_d;
  logic [7:0]  cells_a;
  logic [7:0]  cells_b;
  logic        clk_pin_prev_q;
  logic        clk_pin_rise;
  logic        wr_strobe_prev_q;
  logic        wr_valid_q;
  logic [7:0]  wr_addr_q;
  logic [15:0] wr_data_q;
  logic        wr_active;
  logic        wr_go;
  logic [7:0]  even_byte;
  logic [7:0]  odd_byte;
  logic        hit_a;
  logic        hit_b;
  logic        hit_ma;
  logic        hit_mb;
  logic [7:0]  data_a;
  logic [7:0]  data_b;
  logic [7:0]  data_ma;
  logic [7:0]  data_mb;
  logic [7:0]  load_en_a;
  logic [7:0]  load_en_b;
  logic [7:0]  rd_even_addr;
  logic [7:0]  rd_odd_addr;
  logic [7:0]  rd_even;
  logic [7:0]  rd_odd;
  logic [7:0]  rd_single;
  logic        rd_hit;
  logic        rd_active;
  logic [15:0] rd_word;
  logic [7:0]  ecs_oe;

  ////////////////////////////////////////////////////////////////////////////
  // byte view of every host-visible location
  function automatic logic [7:0] byte_at(input logic [7:0] a, input logic [7:0] ca,
                                         input logic [7:0] cb, input logic [7:0] ma,
                                         input logic [7:0] mb, input logic [23:0] ic);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `PMC_OFF_CELL_A: v = ca;
      `PMC_OFF_CELL_B: v = cb;
      `PMC_OFF_MASK_A: v = ma;
      `PMC_OFF_MASK_B: v = mb;
      `PMC_OFF_IN_A:   v = ic[7:0];
      `PMC_OFF_IN_B:   v = ic[15:8];
      `PMC_OFF_IN_C:   v = ic[23:16];
      default:         v = 8'h00;
    endcase
    return v;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == `PMC_OFF_CELL_A) || (a == `PMC_OFF_CELL_B) ||
           (a == `PMC_OFF_MASK_A) || (a == `PMC_OFF_MASK_B) ||
           (a == `PMC_OFF_IN_A) || (a == `PMC_OFF_IN_B) || (a == `PMC_OFF_IN_C);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // write path: hold address and data while strobe low, commit on rise
  assign wr_active = config_space_select & ~host_write_strobe_n;
  assign wr_go     = wr_valid_q & host_write_strobe_n & ~wr_strobe_prev_q;

  // lane steering of the held data
  assign even_byte = (host_bus_16 & host_byte_swap) ? wr_data_q[15:8]
                                                    : wr_data_q[7:0];
  assign odd_byte  = (host_bus_16 & ~host_byte_swap) ? wr_data_q[15:8]
                                                     : wr_data_q[7:0];

  // target decode: a word access covers the even/odd pair
  assign hit_a  = host_bus_16 ? (wr_addr_q[7:1] == `PMC_OFF_CELL_A >> 1)
                              : (wr_addr_q == `PMC_OFF_CELL_A);
  assign hit_b  = host_bus_16 ? (wr_addr_q[7:1] == `PMC_OFF_CELL_B >> 1)
                              : (wr_addr_q == `PMC_OFF_CELL_B);
  assign hit_ma = host_bus_16 ? (wr_addr_q[7:1] == `PMC_OFF_MASK_A >> 1)
                              : (wr_addr_q == `PMC_OFF_MASK_A);
  assign hit_mb = host_bus_16 ? (wr_addr_q[7:1] == `PMC_OFF_MASK_B >> 1)
                              : (wr_addr_q == `PMC_OFF_MASK_B);
  assign data_a  = host_bus_16 ? even_byte : wr_data_q[7:0];
  assign data_b  = host_bus_16 ? odd_byte : wr_data_q[7:0];
  assign data_ma = host_bus_16 ? even_byte : wr_data_q[7:0];
  assign data_mb = host_bus_16 ? odd_byte : wr_data_q[7:0];

  // masked cell loads
  assign load_en_a = {8{wr_go & hit_a}} & ~mask_a_q;
  assign load_en_b = {8{wr_go & hit_b}} & ~mask_b_q;
  assign mask_a_d  = (wr_go & hit_ma) ? data_ma : mask_a_q;
  assign mask_b_d  = (wr_go & hit_mb) ? data_mb : mask_b_q;

  // held write request and mask registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_strobe_prev_q <= 1'b1;
      wr_valid_q       <= 1'b0;
      wr_addr_q        <= 8'h00;
      wr_data_q        <= 16'h0000;
      mask_a_q         <= `PMC_MASK_RESET;
      mask_b_q         <= `PMC_MASK_RESET;
    end
    else
    begin
      wr_strobe_prev_q <= host_write_strobe_n;
      if (wr_active)
      begin
        wr_valid_q <= 1'b1;
        wr_addr_q  <= host_addr;
        wr_data_q  <= host_wdata;
      end
      else if (host_write_strobe_n)
      begin
        wr_valid_q <= 1'b0;
      end
      mask_a_q <= mask_a_d;
      mask_b_q <= mask_b_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cell clock pin edge detect
  assign clk_pin_rise = cell_clock_pin & ~clk_pin_prev_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      clk_pin_prev_q <= 1'b0;
    else
      clk_pin_prev_q <= cell_clock_pin;
  end

  ////////////////////////////////////////////////////////////////////////////
  // output cell groups on port A and port B
  pmc_out_group #(.N(8), .NATIVE(`PMC_NATIVE_A)) u_grp_a (
    .clk           (clk),
    .rst_n         (rst_n),
    .pt_term       (oc_pt_term[31:0]),
    .pt_second     (oc_pt_second[7:0]),
    .pt_clk        (oc_pt_clk[7:0]),
    .pt_preset     (oc_pt_preset[7:0]),
    .pt_clear0     (oc_pt_clear0[7:0]),
    .pt_clear1     (oc_pt_clear1[7:0]),
    .pt_oe         (oc_pt_oe[7:0]),
    .dir_bit       (port_dir[7:0]),
    .ff_type       (oc_ff_type[7:0]),
    .xor_inv       (oc_xor_inv[7:0]),
    .use_reg       (oc_use_reg[7:0]),
    .clk_pin_sel   (oc_clk_pin_sel[7:0]),
    .clk_pin_rise  (clk_pin_rise),
    .internal_node (oc_internal_node[7:0]),
    .oe_eq_en      (oc_oe_eq_en[7:0]),
    .borrow_en     (oc_borrow_en[7:0]),
    .load_en       (load_en_a),
    .load_data     (data_a),
    .cell_q        (cells_a),
    .fb_q          (cell_feedback_q[7:0]),
    .pin_out_q     (port_a_out_q),
    .pin_oe_n_q    (port_a_oe_n_q)
  );

  pmc_out_group #(.N(8), .NATIVE(`PMC_NATIVE_B)) u_grp_b (
    .clk           (clk),
    .rst_n         (rst_n),
    .pt_term       (oc_pt_term[63:32]),
    .pt_second     (oc_pt_second[15:8]),
    .pt_clk        (oc_pt_clk[15:8]),
    .pt_preset     (oc_pt_preset[15:8]),
    .pt_clear0     (oc_pt_clear0[15:8]),
    .pt_clear1     (oc_pt_clear1[15:8]),
    .pt_oe         (oc_pt_oe[15:8]),
    .dir_bit       (port_dir[15:8]),
    .ff_type       (oc_ff_type[15:8]),
    .xor_inv       (oc_xor_inv[15:8]),
    .use_reg       (oc_use_reg[15:8]),
    .clk_pin_sel   (oc_clk_pin_sel[15:8]),
    .clk_pin_rise  (clk_pin_rise),
    .internal_node (oc_internal_node[15:8]),
    .oe_eq_en      (oc_oe_eq_en[15:8]),
    .borrow_en     (oc_borrow_en[15:8]),
    .load_en       (load_en_b),
    .load_data     (data_b),
    .cell_q        (cells_b),
    .fb_q          (cell_feedback_q[15:8]),
    .pin_out_q     (port_b_out_q),
    .pin_oe_n_q    (port_b_oe_n_q)
  );

  assign port_a_output_cells_q = {cells_b, cells_a};

  ////////////////////////////////////////////////////////////////////////////
  // input cells on ports A, B and C
  pmc_in_port #(.N(8)) u_in_a (
    .clk                  (clk),
    .rst_n                (rst_n),
    .pins_in              (port_a_pins_in),
    .mode                 (ic_mode[7:0]),
    .strobe_sel           (ic_strobe_sel[1:0]),
    .pt_strobe            (ic_pt_strobe[1:0]),
    .address_latch_strobe (address_latch_strobe),
    .cell_q               (input_cell_q[7:0])
  );

  pmc_in_port #(.N(8)) u_in_b (
    .clk                  (clk),
    .rst_n                (rst_n),
    .pins_in              (port_b_pins_in),
    .mode                 (ic_mode[15:8]),
    .strobe_sel           (ic_strobe_sel[3:2]),
    .pt_strobe            (ic_pt_strobe[3:2]),
    .address_latch_strobe (address_latch_strobe),
    .cell_q               (input_cell_q[15:8])
  );

  pmc_in_port #(.N(8)) u_in_c (
    .clk                  (clk),
    .rst_n                (rst_n),
    .pins_in              (port_c_pins_in),
    .mode                 (ic_mode[23:16]),
    .strobe_sel           (ic_strobe_sel[5:4]),
    .pt_strobe            (ic_pt_strobe[5:4]),
    .address_latch_strobe (address_latch_strobe),
    .cell_q               (input_cell_q[23:16])
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path on the internal data bus
  assign rd_active    = config_space_select & ~host_read_strobe_n;
  assign rd_even_addr = {host_addr[7:1], 1'b0};
  assign rd_odd_addr  = {host_addr[7:1], 1'b1};
  assign rd_even   = byte_at(rd_even_addr, cells_a, cells_b, mask_a_q, mask_b_q,
                             input_cell_q);
  assign rd_odd    = byte_at(rd_odd_addr, cells_a, cells_b, mask_a_q, mask_b_q,
                             input_cell_q);
  assign rd_single = byte_at(host_addr, cells_a, cells_b, mask_a_q, mask_b_q,
                             input_cell_q);
  assign rd_hit    = host_bus_16 ? (is_mapped(rd_even_addr) | is_mapped(rd_odd_addr))
                                 : is_mapped(host_addr);
  // lane placement per bus width and byte order
  assign rd_word = !host_bus_16   ? {8'h00, rd_single} :
                   host_byte_swap ? {rd_even, rd_odd} :
                                    {rd_odd, rd_even};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      host_rdata_q      <= 16'h0000;
      host_rdata_oe_n_q <= 1'b1;
    end
    else
    begin
      host_rdata_q      <= (rd_active & rd_hit) ? rd_word : 16'h0000;
      host_rdata_oe_n_q <= ~(rd_active & rd_hit);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external selects: one term, polarity, enable source
  assign ecs_oe = (ecs_oe_dir_sel & ecs_dir) | (~ecs_oe_dir_sel & ecs_pt_oe);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      external_select_q      <= 8'h00;
      external_select_oe_n_q <= 8'hFF;
    end
    else
    begin
      external_select_q      <= ecs_pt ^ ecs_active_low;
      external_select_oe_n_q <= ~ecs_oe;
    end
  end
endmodule

// ==== include/pmc_defs.svh ====
// offsets, reset values and counts for the macrocell array
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
// host offsets inside the configuration space
`define PMC_OFF_IN_A    8'h18
`define PMC_OFF_IN_B    8'h19
`define PMC_OFF_IN_C    8'h1A
`define PMC_OFF_CELL_A  8'h20
`define PMC_OFF_CELL_B  8'h21
`define PMC_OFF_MASK_A  8'h22
`define PMC_OFF_MASK_B  8'h23
// mask register reset value
`define PMC_MASK_RESET  8'h00
// native product terms per cell, and term slots per cell on the array port
`define PMC_NATIVE_A    3
`define PMC_NATIVE_B    4
`define PMC_TERM_SLOTS  4
// borrow ceilings per cell group
`define PMC_BORROW_A    6
`define PMC_BORROW_B_LO 5
`define PMC_BORROW_B_HI 6
`endif

// ==== include/pmc_pkg.sv ====
// types shared by the macrocell array files
package pmc_pkg;
  // storage element behaviour of an output cell
  typedef enum logic [1:0]
  {
    PMC_FF_D  = 2'h0,
    PMC_FF_T  = 2'h1,
    PMC_FF_JK = 2'h3,
    PMC_FF_SR = 2'h2
  } pmc_ff_e;
  // input cell behaviour
  typedef enum logic [1:0]
  {
    PMC_IC_PASS  = 2'h0,
    PMC_IC_LATCH = 2'h1,
    PMC_IC_REG   = 2'h3
  } pmc_imc_e;
endpackage

// ==== design/pmc_in_port.sv ====
// eight input cells serving one port
`timescale 1ns/100ps
module pmc_in_port #(
  parameter int N = 8
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [N-1:0]              pins_in,
  input  pmc_pkg::pmc_imc_e [N-1:0]      mode,
  input  wire logic [1:0]                strobe_sel,
  input  wire logic [1:0]                pt_strobe,
  input  wire logic                      address_latch_strobe,
  output logic [N-1:0]                   cell_q
);
  import pmc_pkg::*;

  logic [1:0]   en;
  logic [1:0]   en_prev_q;
  logic [1:0]   en_rise;
  logic [N-1:0] cell_d;

  // low nibble and high nibble each pick a product term or the address strobe
  assign en = (strobe_sel & {2{address_latch_strobe}}) | (~strobe_sel & pt_strobe);
  assign en_rise = en & ~en_prev_q;

  // per cell latch, register or pass-through
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_cell
      localparam int H = (i < 4) ? 0 : 1;
      always_comb
      begin
        case (mode[i])
          PMC_IC_PASS:  cell_d[i] = pins_in[i];
          PMC_IC_LATCH: cell_d[i] = en[H] ? pins_in[i] : cell_q[i];
          PMC_IC_REG:   cell_d[i] = en_rise[H] ? pins_in[i] : cell_q[i];
          default:      cell_d[i] = cell_q[i];
        endcase
      end
    end
  endgenerate

  // state of the cells and strobe history
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cell_q    <= '0;
      en_prev_q <= '0;
    end
    else
    begin
      cell_q    <= cell_d;
      en_prev_q <= en;
    end
  end
endmodule

// ==== design/pmc_out_group.sv ====
// one group of eight output cells with term sharing and pin drive
`timescale 1ns/100ps
module pmc_out_group #(
  parameter int N      = 8,
  parameter int NATIVE = 3
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [N*4-1:0]       pt_term,
  input  wire logic [N-1:0]         pt_second,
  input  wire logic [N-1:0]         pt_clk,
  input  wire logic [N-1:0]         pt_preset,
  input  wire logic [N-1:0]         pt_clear0,
  input  wire logic [N-1:0]         pt_clear1,
  input  wire logic [N-1:0]         pt_oe,
  input  wire logic [N-1:0]         dir_bit,
  input  pmc_pkg::pmc_ff_e [N-1:0]  ff_type,
  input  wire logic [N-1:0]         xor_inv,
  input  wire logic [N-1:0]         use_reg,
  input  wire logic [N-1:0]         clk_pin_sel,
  input  wire logic                 clk_pin_rise,
  input  wire logic [N-1:0]         internal_node,
  input  wire logic [N-1:0]         oe_eq_en,
  input  wire logic [N-1:0]         borrow_en,
  input  wire logic [N-1:0]         load_en,
  input  wire logic [N-1:0]         load_data,
  output logic [N-1:0]              cell_q,
  output logic [N-1:0]              fb_q,
  output logic [N-1:0]              pin_out_q,
  output logic [N-1:0]              pin_oe_n_q
);
  import pmc_pkg::*;

  localparam logic [3:0] NMASK = 4'((1 << NATIVE) - 1);

  logic [N-1:0] nat;
  logic [N-1:0] sum;
  logic [N-1:0] d;
  logic [N-1:0] nxt;
  logic [N-1:0] cell_d;
  logic [N-1:0] clk_ev;
  logic [N-1:0] pt_clk_prev_q;
  logic [N-1:0] sel;
  logic [N-1:0] oe_d;

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_cell
      localparam int NB = (i + 1) % N;
      localparam int PV = (i + N - 1) % N;
      // own terms, lent terms vanish from the lender
      assign nat[i] = |(pt_term[i*4 +: 4] & NMASK);
      assign sum[i] = (borrow_en[PV] ? 1'b0 : nat[i]) | (borrow_en[i] & nat[NB]);
      assign d[i] = sum[i] ^ xor_inv[i];
      assign clk_ev[i] = clk_pin_sel[i] ? clk_pin_rise
                                        : (pt_clk[i] & ~pt_clk_prev_q[i]);
      // next state by storage type
      always_comb
      begin
        case (ff_type[i])
          PMC_FF_D:  nxt[i] = d[i];
          PMC_FF_T:  nxt[i] = cell_q[i] ^ d[i];
          PMC_FF_JK: nxt[i] = (d[i] & ~cell_q[i]) | (~pt_second[i] & cell_q[i]);
          PMC_FF_SR: nxt[i] = d[i] | (~pt_second[i] & cell_q[i]);
          default:   nxt[i] = cell_q[i];
        endcase
      end
      // host load beats clear, preset and clock
      assign cell_d[i] = load_en[i] ? load_data[i] :
                         (pt_clear0[i] | pt_clear1[i]) ? 1'b0 :
                         pt_preset[i] ? 1'b1 :
                         clk_ev[i] ? nxt[i] : cell_q[i];
      assign sel[i] = use_reg[i] ? cell_q[i] : d[i];
      // driver enable, off for internal nodes
      assign oe_d[i] = ~internal_node[i] &
                       (oe_eq_en[i] ? (pt_oe[i] | dir_bit[i]) : 1'b1);
    end
  endgenerate

  // cell state, feedback and pins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cell_q        <= '0;
      fb_q          <= '0;
      pin_out_q     <= '0;
      pin_oe_n_q    <= '1;
      pt_clk_prev_q <= '0;
    end
    else
    begin
      cell_q        <= cell_d;
      fb_q          <= sel;
      pin_out_q     <= sel;
      pin_oe_n_q    <= ~oe_d;
      pt_clk_prev_q <= pt_clk;
    end
  end
endmodule

// ==== testbench/pmc_chk.sv ====
// assertion checker for the macrocell array top
`timescale 1ns/100ps
module pmc_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        config_space_select,
  input wire logic [7:0]  host_addr,
  input wire logic        host_read_strobe_n,
  input wire logic        host_write_strobe_n,
  input wire logic [15:0] host_rdata_q,
  input wire logic        host_rdata_oe_n_q,
  input wire logic [7:0]  ecs_pt,
  input wire logic [7:0]  ecs_active_low,
  input wire logic [7:0]  ecs_pt_oe,
  input wire logic [7:0]  ecs_dir,
  input wire logic [7:0]  ecs_oe_dir_sel,
  input wire logic [7:0]  external_select_q,
  input wire logic [7:0]  external_select_oe_n_q,
  input wire logic [15:0] oc_pt_preset,
  input wire logic [15:0] oc_pt_clear0,
  input wire logic [15:0] oc_pt_clear1,
  input wire logic [15:0] port_a_output_cells_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // mapped config offsets and a host read request
  wire mapped = host_addr inside {[8'h18:8'h1A], [8'h20:8'h23]};
  sequence s_rd;
    config_space_select && !host_read_strobe_n;
  endsequence
  a_read_unmapped: assert property (s_rd ##0 !mapped |=> host_rdata_oe_n_q && host_rdata_q == 16'h0000)
    else $error("unmapped read answered");
  a_read_drive: assert property (s_rd ##0 mapped |=> !host_rdata_oe_n_q)
    else $error("mapped read not driven");
  a_read_idle: assert property (!config_space_select |=> host_rdata_oe_n_q)
    else $error("bus driven without select");
  a_ecs_polarity: assert property (1'b1 |=> external_select_q == $past(ecs_pt ^ ecs_active_low))
    else $error("select polarity wrong");
  a_ecs_enable: assert property (1'b1 |=> external_select_oe_n_q ==
    $past(~((ecs_oe_dir_sel & ecs_dir) | (~ecs_oe_dir_sel & ecs_pt_oe))))
    else $error("select enable wrong");
  a_clear_zero: assert property ((oc_pt_clear0[0] && host_write_strobe_n) [*5] |-> !port_a_output_cells_q[0])
    else $error("first clear term ignored");
  a_clear_second: assert property ((oc_pt_clear1[2] && host_write_strobe_n) [*5] |-> !port_a_output_cells_q[2])
    else $error("second clear term ignored");
  a_preset_one: assert property ((oc_pt_preset[1] && !oc_pt_clear0[1] && !oc_pt_clear1[1]
    && host_write_strobe_n) [*5] |-> port_a_output_cells_q[1])
    else $error("preset term ignored");
endmodule

// ==== testbench/pmc_host_bfm.sv ====
// host bus model: config-space writes and reads
`timescale 1ns/100ps
module pmc_host_bfm (
  input  wire logic        clk,
  input  wire logic [15:0] host_rdata_q,
  output logic             config_space_select,
  output logic [7:0]       host_addr,
  output logic [15:0]      host_wdata,
  output logic             host_write_strobe_n,
  output logic             host_read_strobe_n
);
  // idle bus at time zero
  initial
  begin
    {config_space_select, host_addr, host_wdata} = '0;
    {host_write_strobe_n, host_read_strobe_n} = 2'b11;
  end
  // write: strobe low one cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic cs);
    @(negedge clk);
    config_space_select = cs;
    host_addr = a;
    host_wdata = d;
    host_write_strobe_n = 1'b0;
    @(negedge clk);
    host_write_strobe_n = 1'b1;
    @(negedge clk);
    config_space_select = 1'b0;
    host_wdata = ~d;
  endtask
  // read: answer registered at the take edge, sampled on the next falling edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk);
    config_space_select = 1'b1;
    host_addr = a;
    host_read_strobe_n = 1'b0;
    @(negedge clk);
    d = host_rdata_q;
    host_read_strobe_n = 1'b1;
    config_space_select = 1'b0;
  endtask
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the macrocell array top
`timescale 1ns/100ps
`include "pmc_defs.svh"
module testbench;
  import pmc_pkg::*;
  logic clk, rst_n, host_bus_16, host_byte_swap, address_latch_strobe, cell_clock_pin;
  logic config_space_select, host_write_strobe_n, host_read_strobe_n, host_rdata_oe_n_q;
  logic [63:0] oc_pt_term;
  logic [15:0] oc_pt_second, oc_pt_clk, oc_pt_preset, oc_pt_clear0, oc_pt_clear1, oc_pt_oe;
  logic [15:0] port_dir, oc_xor_inv, oc_use_reg, oc_clk_pin_sel, oc_internal_node, oc_oe_eq_en;
  logic [15:0] oc_borrow_en, host_wdata, host_rdata_q, cell_feedback_q, port_a_output_cells_q, rv;
  logic [7:0]  port_a_pins_in, port_b_pins_in, port_c_pins_in, ecs_pt, ecs_active_low, ecs_pt_oe;
  logic [7:0]  ecs_dir, ecs_oe_dir_sel, host_addr, port_a_out_q, port_a_oe_n_q, port_b_out_q;
  logic [7:0]  port_b_oe_n_q, external_select_q, external_select_oe_n_q;
  logic [5:0]  ic_strobe_sel, ic_pt_strobe;
  logic [23:0] input_cell_q;
  pmc_ff_e [15:0] oc_ff_type;
  pmc_imc_e [23:0] ic_mode;
  int num_errors, tests_run;
  pmc_top dut_u (.*);
  pmc_host_bfm host_u (.*);
  // free-running clock
  always #2.5 clk = ~clk;
  // one comparison
  task automatic chk(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // read through the host model, low byte only on the narrow bus
  task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
    host_u.rd(a, rv);
    chk(nm, e, host_bus_16 ? rv : {8'h00, rv[7:0]});
  endtask
  // counts and verdict
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #20000;
    num_errors++;
    complete_run();
  end
  // main sequence
  initial
  begin
    {clk, rst_n, host_bus_16, host_byte_swap, address_latch_strobe, cell_clock_pin} = '0;
    {oc_pt_term, oc_pt_second, oc_pt_clk, oc_pt_preset, oc_pt_clear0, oc_pt_clear1} = '0;
    {oc_pt_oe, port_dir, oc_xor_inv, oc_use_reg, oc_clk_pin_sel, oc_internal_node} = '0;
    {oc_oe_eq_en, oc_borrow_en, port_a_pins_in, port_b_pins_in, port_c_pins_in} = '0;
    {ecs_pt, ecs_active_low, ecs_pt_oe, ecs_dir, ecs_oe_dir_sel, ic_strobe_sel, ic_pt_strobe} = '0;
    {num_errors, tests_run} = '0;
    oc_ff_type = {16{PMC_FF_D}};
    ic_mode = {24{PMC_IC_PASS}};
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    rchk("mask a", `PMC_OFF_MASK_A, 16'h0000);
    rchk("mask b", `PMC_OFF_MASK_B, 16'h0000);
    host_u.wr(`PMC_OFF_CELL_A, 16'h005A, 1'b1);
    rchk("cell a", `PMC_OFF_CELL_A, 16'h005A);
    host_u.wr(`PMC_OFF_MASK_A, 16'h000F, 1'b1);
    host_u.wr(`PMC_OFF_CELL_A, 16'h00A5, 1'b1);
    rchk("masked a", `PMC_OFF_CELL_A, 16'h00AA);
    host_u.wr(`PMC_OFF_CELL_A, 16'h00FF, 1'b0);
    rchk("no select", `PMC_OFF_CELL_A, 16'h00AA);
    rchk("unmapped", 8'h30, 16'h0000);
    host_u.wr(`PMC_OFF_MASK_A, 16'h0000, 1'b1);
    host_bus_16 = 1'b1;
    host_u.wr(`PMC_OFF_CELL_A, 16'h3C96, 1'b1);
    @(negedge clk);
    chk("cells wide", 16'h3C96, port_a_output_cells_q);
    host_byte_swap = 1'b1;
    host_u.wr(`PMC_OFF_CELL_A, 16'h1534, 1'b1);
    @(negedge clk);
    chk("cells swapped", 16'h3415, port_a_output_cells_q);
    rchk("read swapped", `PMC_OFF_CELL_A, 16'h1534);
    {host_bus_16, host_byte_swap} = 2'b00;
    host_u.wr(`PMC_OFF_CELL_B, 16'hFF6B, 1'b1);
    rchk("cell b", `PMC_OFF_CELL_B, 16'h006B);
    port_a_pins_in = 8'hC3;
    port_c_pins_in = 8'h5E;
    rchk("in a", `PMC_OFF_IN_A, 16'h00C3);
    rchk("in c", `PMC_OFF_IN_C, 16'h005E);
    oc_pt_clear0 = 16'h0001;
    oc_pt_clear1 = 16'h0004;
    oc_pt_preset = 16'h0002;
    {ecs_pt, ecs_active_low, ecs_oe_dir_sel, ecs_dir, ecs_pt_oe} = 40'hA5_0FF0_3003;
    {oc_xor_inv, oc_oe_eq_en, oc_pt_oe, port_dir} = 64'h0F0F_00FF_0003_0030;
    repeat (6) @(negedge clk);
    chk("clear preset", 16'h0002, port_a_output_cells_q & 16'h0007);
    chk("select data", 16'h00AA, {8'h00, external_select_q});
    chk("select enable", 16'h00CC, {8'h00, external_select_oe_n_q});
    chk("pin enable a", 16'h00CC, {8'h00, port_a_oe_n_q});
    chk("pin enable b", 16'h0000, {8'h00, port_b_oe_n_q});
    chk("pins", 16'h0F0F, {port_b_out_q, port_a_out_q});
    chk("feedback", 16'h0F0F, cell_feedback_q);
    complete_run();
  end
endmodule
bind pmc_top pmc_chk chk_u (.*);
